// ==== logic/mtc_consts.vh ====
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH

// Register offsets
`define MTC_ADDR_SOFT_RESET      8'h10
`define MTC_ADDR_OUTPUT_GATE     8'h11
`define MTC_ADDR_PIN_SELECT      8'h12
`define MTC_ADDR_ALIGN_CTL       8'h13
`define MTC_ADDR_CORE_RUN        8'h14
`define MTC_ADDR_OSC_RUN         8'h15
`define MTC_ADDR_TEST_A          8'h16
`define MTC_ADDR_UPDATE_LINE     8'h17
`define MTC_ADDR_TEST_B          8'h18
`define MTC_ADDR_TEST_C          8'h19
`define MTC_ADDR_TEST_D          8'h1A
`define MTC_ADDR_TEST_E          8'h1B
`define MTC_ADDR_GATE_SELECT     8'h1C
`define MTC_ADDR_GATE_MASK       8'h1D
`define MTC_ADDR_UNUSED          8'h1E
`define MTC_ADDR_COUNTER_CLAMP   8'h1F

// Reset values
`define MTC_RST_SOFT_RESET       1'h0
`define MTC_RST_OUTPUT_GATE      1'h0
`define MTC_RST_PIN_SELECT       5'h01
`define MTC_RST_ALIGN_CTL        26'h0000061
`define MTC_RST_CORE_RUN         1'h0
`define MTC_RST_OSC_RUN          1'h0
`define MTC_RST_TEST_A           28'h0000001
`define MTC_RST_UPDATE_LINE      14'h0000
`define MTC_RST_TEST_B           28'h0000000
`define MTC_RST_TEST_C           28'h0000000
`define MTC_RST_TEST_D           28'h0000000
`define MTC_RST_TEST_E           28'h000000A
`define MTC_RST_GATE_SELECT      24'h000000
`define MTC_RST_GATE_MASK        25'h0000000
`define MTC_RST_COUNTER_CLAMP    2'h3

// Field positions of alignment_control
`define MTC_AL_EXT_ENABLE        0
`define MTC_AL_POLARITY          1
`define MTC_AL_CLOCK_HOLD        2
`define MTC_AL_ENHANCED          3
`define MTC_AL_LINE_MASK         4
`define MTC_AL_FRAME_MASK        5
`define MTC_AL_VCLK_MASK         6
`define MTC_AL_SINGLE_EDGE       14
`define MTC_AL_SHUT_CLR_AFTER    15
`define MTC_AL_GP_CLR            16
`define MTC_AL_FIELD_STEP        17
`define MTC_AL_SW_TRIGGER        24
`define MTC_AL_SHUT_HOLD_CLR     25

// Field positions of update_line_ctl, gate_mask_override, counter_clamp_options
`define MTC_UPD_LINE_MSB         12
`define MTC_UPD_BLOCK            13
`define MTC_GM_OVERRIDE          24
`define MTC_CC_WIDE_COUNTER      0
`define MTC_CC_CLAMP_INHIBIT     1

// Bus widths and channel count
`define MTC_ADDR_W               8
`define MTC_DATA_W               28
`define MTC_VCLK_N               24

`endif

// ==== logic/mtc_misc_regs.v ====
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "mtc_consts.vh"

module mtc_misc_regs #(
  parameter FIELD_W = 8
) (
  input  wire                    sys_clk,
  input  wire                    arst_n,
  input  wire [`MTC_ADDR_W-1:0]  regAddr,
  input  wire [`MTC_DATA_W-1:0]  regWrData,
  input  wire                    regWrEn,
  input  wire                    regRdEn,
  output reg  [`MTC_DATA_W-1:0]  regRdData_r,
  input  wire                    sharedPin,
  input  wire                    frameSyncIn,
  input  wire                    lineSyncIn,
  input  wire [12:0]             lineCount,
  input  wire                    pixelBlank,
  input  wire                    clampPulse,
  input  wire [`MTC_VCLK_N-1:0]  vertClkIn,
  input  wire [`MTC_VCLK_N-1:0]  fieldGateMask,
  output reg                     softResetOut_r,
  output reg                     pinResetReq_r,
  output reg                     alignEvent_r,
  output reg                     clockHold_r,
  output reg                     lineSyncOut_r,
  output reg                     frameSyncOut_r,
  output reg  [`MTC_VCLK_N-1:0]  vertClkOut_r,
  output reg  [`MTC_VCLK_N-1:0]  sensorGateOut_r,
  output reg                     shutterClear_r,
  output reg                     gpOutClear_r,
  output reg  [FIELD_W-1:0]      fieldCount_r,
  output reg                     coreResetN_r,
  output reg                     oscRun_r,
  output reg                     updateLoad_r,
  output reg                     wideCounterEn_r,
  output reg                     clampOut_r,
  output reg                     outputsActive_r
);

  // Register storage
  reg                     softReset_r;
  reg                     outGatePend_r;
  reg  [4:0]              pinSelect_r;
  reg  [25:0]             alignCtl_r;
  reg                     coreRun_r;
  reg                     oscRunBit_r;
  reg  [`MTC_DATA_W-1:0]  testA_r;
  reg  [13:0]             updateCtl_r;
  reg  [`MTC_DATA_W-1:0]  testB_r;
  reg  [`MTC_DATA_W-1:0]  testC_r;
  reg  [`MTC_DATA_W-1:0]  testD_r;
  reg  [`MTC_DATA_W-1:0]  testE_r;
  reg  [23:0]             gateSelect_r;
  reg  [24:0]             gateMaskCtl_r;
  reg  [1:0]              counterClamp_r;

  // Pin synchroniser and edge history
  reg                     pinMeta_r;
  reg                     pinSync_r;
  reg                     alignPrev_r;
  reg                     frameSyncPrev_r;
  reg                     lineSyncPrev_r;

  // Decoded strobes
  wire                    wrHit;
  wire                    wrSoftReset;
  wire                    wrAlign;
  wire                    swTrigger;

  // Alignment decode
  wire                    extAlignOn;
  wire                    extActive;
  wire                    alignActive;
  wire                    alignLead;
  wire                    alignTrail;
  wire                    alignFire;
  wire                    enhancedOn;
  wire                    holdNow;

  // Frame and line timing
  wire                    frameEdge;
  wire                    lineEdge;
  wire                    updateLineHit;

  // Gate masking
  wire [`MTC_VCLK_N-1:0]  gateMaskEff;
  wire                    vclkMasked;

  reg  [`MTC_DATA_W-1:0]  rdData_nxt;
  reg  [FIELD_W-1:0]      fieldCount_nxt;

  // Write decode; no writes land while soft reset is being applied
  assign wrHit       = regWrEn & ~softReset_r;
  assign wrSoftReset = wrHit & (regAddr == `MTC_ADDR_SOFT_RESET);
  assign wrAlign     = wrHit & (regAddr == `MTC_ADDR_ALIGN_CTL);
  assign swTrigger   = alignCtl_r[`MTC_AL_SW_TRIGGER];

  // Shared pin routing and polarity
  assign extAlignOn  = alignCtl_r[`MTC_AL_EXT_ENABLE] & ~pinSelect_r[0];
  assign extActive   = extAlignOn & (pinSync_r == alignCtl_r[`MTC_AL_POLARITY]);
  assign alignActive = extActive;
  assign alignLead   = alignActive & ~alignPrev_r;
  assign alignTrail  = ~alignActive & alignPrev_r;

  // Event on leading edge in single-edge mode, else at pulse end
  assign alignFire   = (alignCtl_r[`MTC_AL_SINGLE_EDGE] ? alignLead : alignTrail)
                     | swTrigger;
  assign enhancedOn  = alignCtl_r[`MTC_AL_ENHANCED];
  assign holdNow     = alignCtl_r[`MTC_AL_CLOCK_HOLD] & alignActive;

  // Frame and line edge detection from the timing core
  assign frameEdge     = frameSyncIn & ~frameSyncPrev_r;
  assign lineEdge      = lineSyncIn & ~lineSyncPrev_r;
  assign updateLineHit = lineEdge & (lineCount == updateCtl_r[`MTC_UPD_LINE_MSB:0]);

  // Mask source select
  assign gateMaskEff = gateMaskCtl_r[`MTC_GM_OVERRIDE] ? gateMaskCtl_r[23:0]
                                                       : fieldGateMask;
  assign vclkMasked  = holdNow & alignCtl_r[`MTC_AL_VCLK_MASK];

  // Two-flop synchroniser for the shared pin
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
    end
    else
    begin
      pinMeta_r <= sharedPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // Register file with asynchronous and soft reset
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      softReset_r    <= `MTC_RST_SOFT_RESET;
      outGatePend_r  <= `MTC_RST_OUTPUT_GATE;
      pinSelect_r    <= `MTC_RST_PIN_SELECT;
      alignCtl_r     <= `MTC_RST_ALIGN_CTL;
      coreRun_r      <= `MTC_RST_CORE_RUN;
      oscRunBit_r    <= `MTC_RST_OSC_RUN;
      testA_r        <= `MTC_RST_TEST_A;
      updateCtl_r    <= `MTC_RST_UPDATE_LINE;
      testB_r        <= `MTC_RST_TEST_B;
      testC_r        <= `MTC_RST_TEST_C;
      testD_r        <= `MTC_RST_TEST_D;
      testE_r        <= `MTC_RST_TEST_E;
      gateSelect_r   <= `MTC_RST_GATE_SELECT;
      gateMaskCtl_r  <= `MTC_RST_GATE_MASK;
      counterClamp_r <= `MTC_RST_COUNTER_CLAMP;
    end
    else if (softReset_r)
    begin
      // Defaults restored, request bit drops by itself
      softReset_r    <= `MTC_RST_SOFT_RESET;
      outGatePend_r  <= `MTC_RST_OUTPUT_GATE;
      pinSelect_r    <= `MTC_RST_PIN_SELECT;
      alignCtl_r     <= `MTC_RST_ALIGN_CTL;
      coreRun_r      <= `MTC_RST_CORE_RUN;
      oscRunBit_r    <= `MTC_RST_OSC_RUN;
      testA_r        <= `MTC_RST_TEST_A;
      updateCtl_r    <= `MTC_RST_UPDATE_LINE;
      testB_r        <= `MTC_RST_TEST_B;
      testC_r        <= `MTC_RST_TEST_C;
      testD_r        <= `MTC_RST_TEST_D;
      testE_r        <= `MTC_RST_TEST_E;
      gateSelect_r   <= `MTC_RST_GATE_SELECT;
      gateMaskCtl_r  <= `MTC_RST_GATE_MASK;
      counterClamp_r <= `MTC_RST_COUNTER_CLAMP;
    end
    else
    begin
      // Software trigger self-clears once fired; a new write wins
      if (swTrigger)
        alignCtl_r[`MTC_AL_SW_TRIGGER] <= 1'b0;
      if (wrSoftReset)
        softReset_r <= regWrData[0];
      // Serial-type registers take effect right after the write
      if (wrHit)
      begin
        case (regAddr)
          `MTC_ADDR_OUTPUT_GATE:   outGatePend_r  <= regWrData[0];
          `MTC_ADDR_PIN_SELECT:    pinSelect_r    <= regWrData[4:0];
          `MTC_ADDR_ALIGN_CTL:     alignCtl_r     <= regWrData[25:0];
          `MTC_ADDR_CORE_RUN:      coreRun_r      <= regWrData[0];
          `MTC_ADDR_OSC_RUN:       oscRunBit_r    <= regWrData[0];
          `MTC_ADDR_TEST_A:        testA_r        <= regWrData;
          `MTC_ADDR_UPDATE_LINE:   updateCtl_r    <= regWrData[13:0];
          `MTC_ADDR_TEST_B:        testB_r        <= regWrData;
          `MTC_ADDR_TEST_C:        testC_r        <= regWrData;
          `MTC_ADDR_TEST_D:        testD_r        <= regWrData;
          `MTC_ADDR_TEST_E:        testE_r        <= regWrData;
          `MTC_ADDR_GATE_SELECT:   gateSelect_r   <= regWrData[23:0];
          `MTC_ADDR_GATE_MASK:     gateMaskCtl_r  <= regWrData[24:0];
          `MTC_ADDR_COUNTER_CLAMP: counterClamp_r <= regWrData[1:0];
          default:                 ;
        endcase
      end
    end
  end

  // Read mux; unused word and unmapped offsets read zero
  always @*
  begin
    rdData_nxt = {`MTC_DATA_W{1'b0}};
    case (regAddr)
      `MTC_ADDR_SOFT_RESET:    rdData_nxt[0]     = softReset_r;
      `MTC_ADDR_OUTPUT_GATE:   rdData_nxt[0]     = outGatePend_r;
      `MTC_ADDR_PIN_SELECT:    rdData_nxt[4:0]   = pinSelect_r;
      `MTC_ADDR_ALIGN_CTL:     rdData_nxt[25:0]  = alignCtl_r;
      `MTC_ADDR_CORE_RUN:      rdData_nxt[0]     = coreRun_r;
      `MTC_ADDR_OSC_RUN:       rdData_nxt[0]     = oscRunBit_r;
      `MTC_ADDR_TEST_A:        rdData_nxt        = testA_r;
      `MTC_ADDR_UPDATE_LINE:   rdData_nxt[13:0]  = updateCtl_r;
      `MTC_ADDR_TEST_B:        rdData_nxt        = testB_r;
      `MTC_ADDR_TEST_C:        rdData_nxt        = testC_r;
      `MTC_ADDR_TEST_D:        rdData_nxt        = testD_r;
      `MTC_ADDR_TEST_E:        rdData_nxt        = testE_r;
      `MTC_ADDR_GATE_SELECT:   rdData_nxt[23:0]  = gateSelect_r;
      `MTC_ADDR_GATE_MASK:     rdData_nxt[24:0]  = gateMaskCtl_r;
      `MTC_ADDR_COUNTER_CLAMP: rdData_nxt[1:0]   = counterClamp_r;
      default:                 rdData_nxt        = {`MTC_DATA_W{1'b0}};
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdData_r <= {`MTC_DATA_W{1'b0}};
    else if (regRdEn)
      regRdData_r <= rdData_nxt;
    else
      regRdData_r <= {`MTC_DATA_W{1'b0}};
  end

  // Field counter next value on alignment
  always @*
  begin
    fieldCount_nxt = fieldCount_r;
    if (alignFire)
    begin
      if (alignCtl_r[`MTC_AL_FIELD_STEP])
        fieldCount_nxt = fieldCount_r + {{(FIELD_W-1){1'b0}}, 1'b1};
      else
        fieldCount_nxt = {FIELD_W{1'b0}};
    end
  end

  // Edge history, field counter and alignment outputs
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      alignPrev_r     <= 1'b0;
      frameSyncPrev_r <= 1'b0;
      lineSyncPrev_r  <= 1'b0;
      fieldCount_r    <= {FIELD_W{1'b0}};
      alignEvent_r    <= 1'b0;
      clockHold_r     <= 1'b0;
      shutterClear_r  <= 1'b0;
      gpOutClear_r    <= 1'b0;
      pinResetReq_r   <= 1'b0;
      softResetOut_r  <= 1'b0;
    end
    else
    begin
      alignPrev_r     <= alignActive;
      frameSyncPrev_r <= frameSyncIn;
      lineSyncPrev_r  <= lineSyncIn;
      fieldCount_r    <= fieldCount_nxt;
      alignEvent_r    <= alignFire;
      clockHold_r     <= holdNow;
      // Shutter reset: forced hold, or one-cycle clear after alignment
      shutterClear_r  <= alignCtl_r[`MTC_AL_SHUT_HOLD_CLR]
                       | (alignFire & enhancedOn & alignCtl_r[`MTC_AL_SHUT_CLR_AFTER])
                       | (alignFire & enhancedOn & alignCtl_r[`MTC_AL_GP_CLR]);
      gpOutClear_r    <= alignFire & enhancedOn & alignCtl_r[`MTC_AL_GP_CLR];
      // Low pin level while configured as reset pin
      pinResetReq_r   <= pinSelect_r[0] & ~pinSync_r;
      // Tells the rest of the register space to reload defaults
      softResetOut_r  <= softReset_r;
    end
  end

  // Output gate loads at frame edge; update strobe at chosen line
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outputsActive_r <= 1'b0;
      updateLoad_r    <= 1'b0;
      coreResetN_r    <= 1'b0;
      oscRun_r        <= 1'b0;
      wideCounterEn_r <= 1'b1;
    end
    else
    begin
      if (softReset_r)
        outputsActive_r <= 1'b0;
      else if (frameEdge)
        outputsActive_r <= outGatePend_r;
      updateLoad_r    <= updateLineHit & ~updateCtl_r[`MTC_UPD_BLOCK];
      coreResetN_r    <= coreRun_r;
      oscRun_r        <= oscRunBit_r;
      wideCounterEn_r <= counterClamp_r[`MTC_CC_WIDE_COUNTER];
    end
  end

  // Sync and clamp outputs held inactive while gated off
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lineSyncOut_r  <= 1'b0;
      frameSyncOut_r <= 1'b0;
      clampOut_r     <= 1'b0;
    end
    else
    begin
      lineSyncOut_r  <= outputsActive_r & lineSyncIn
                      & ~(holdNow & alignCtl_r[`MTC_AL_LINE_MASK]);
      frameSyncOut_r <= outputsActive_r & frameSyncIn
                      & ~(holdNow & alignCtl_r[`MTC_AL_FRAME_MASK]);
      clampOut_r     <= outputsActive_r & clampPulse
                      & ~(counterClamp_r[`MTC_CC_CLAMP_INHIBIT] & pixelBlank);
    end
  end

  // Per-channel vertical clock and sensor gate routing
  genvar ch;
  generate
    for (ch = 0; ch < `MTC_VCLK_N; ch = ch + 1)
    begin : gVclk
      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          vertClkOut_r[ch]    <= 1'b0;
          sensorGateOut_r[ch] <= 1'b0;
        end
        else
        begin
          // Non-gate channels pass as vertical clocks
          vertClkOut_r[ch]    <= outputsActive_r & ~vclkMasked
                               & vertClkIn[ch] & ~gateSelect_r[ch];
          // Gate channels, suppressed by the active mask
          sensorGateOut_r[ch] <= outputsActive_r & ~vclkMasked
                               & vertClkIn[ch] & gateSelect_r[ch]
                               & ~gateMaskEff[ch];
        end
      end
    end
  endgenerate

endmodule // mtc_misc_regs

// ==== testbench/mtc_misc_regs_assertions.sv ====
`timescale 1ns/1ps
module mtc_misc_regs_assertions (
  input wire        sys_clk,
  input wire        arst_n,
  input wire [7:0]  regAddr,
  input wire [27:0] regWrData,
  input wire        regWrEn,
  input wire        regRdEn,
  input wire [27:0] regRdData_r,
  input wire        frameSyncIn,
  input wire        lineSyncIn,
  input wire        clampPulse,
  input wire [23:0] vertClkIn,
  input wire        softResetOut_r,
  input wire        alignEvent_r,
  input wire [23:0] vertClkOut_r,
  input wire [23:0] sensorGateOut_r,
  input wire        gpOutClear_r,
  input wire        coreResetN_r,
  input wire        updateLoad_r,
  input wire        clampOut_r,
  input wire        outputsActive_r
);
  // One clock domain, one reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Register bus answers
  read_idle_a: assert property (!$past(regRdEn) |-> regRdData_r == 28'h0)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (regRdEn && (regAddr == 8'h1E || regAddr < 8'h10)
    |=> regRdData_r == 28'h0) else $error("unmapped read not zero");
  // Run bit reaches the core reset two cycles on
  core_run_a: assert property (regWrEn && regAddr == 8'h14
    |-> ##2 coreResetN_r == $past(regWrData[0], 2)) else $error("core run late");
  // Soft reset pulse and its effect
  soft_pulse_a: assert property (regWrEn && regAddr == 8'h10 && regWrData[0]
    |-> ##2 softResetOut_r ##1 !softResetOut_r) else $error("soft reset pulse");
  soft_gate_a: assert property (softResetOut_r |-> !outputsActive_r)
    else $error("outputs active after soft reset");
  // Output gate only opens after a frame edge
  gate_frame_a: assert property ($rose(outputsActive_r)
    |-> $past(frameSyncIn) && !$past(frameSyncIn, 2)) else $error("gate off frame");
  gp_clear_a: assert property (gpOutClear_r |-> alignEvent_r)
    else $error("gp clear without alignment");
  update_edge_a: assert property (updateLoad_r
    |-> $past(lineSyncIn) && !$past(lineSyncIn, 2)) else $error("update off line");
  clamp_src_a: assert property (clampOut_r |-> $past(clampPulse))
    else $error("clamp without pulse");
  gate_disjoint_a: assert property ((vertClkOut_r & sensorGateOut_r) == 24'h0)
    else $error("channel both clock and gate");
  gate_src_a: assert property ((sensorGateOut_r & ~$past(vertClkIn)) == 24'h0)
    else $error("gate without vertical clock");
endmodule // mtc_misc_regs_assertions

bind mtc_misc_regs mtc_misc_regs_assertions i_mtc_misc_regs_assertions (
  .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
  .frameSyncIn(frameSyncIn), .lineSyncIn(lineSyncIn), .clampPulse(clampPulse),
  .vertClkIn(vertClkIn), .softResetOut_r(softResetOut_r), .alignEvent_r(alignEvent_r),
  .vertClkOut_r(vertClkOut_r), .sensorGateOut_r(sensorGateOut_r),
  .gpOutClear_r(gpOutClear_r), .coreResetN_r(coreResetN_r),
  .updateLoad_r(updateLoad_r), .clampOut_r(clampOut_r),
  .outputsActive_r(outputsActive_r));

// ==== testbench/mtc_misc_regs_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module mtc_misc_regs_tb;
  reg         sys_clk = 0, arst_n = 0, regWrEn = 0, regRdEn = 0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [27:0] regWrData = 28'h0;
  reg         sharedPin = 1, frameSyncIn = 0, lineSyncIn = 0;
  reg         pixelBlank = 0, clampPulse = 0;
  reg  [12:0] lineCount = 13'h0;
  reg  [23:0] vertClkIn = 24'h0, fieldGateMask = 24'h0;
  wire [27:0] rdData;
  wire [23:0] vOut, gOut;
  wire [7:0]  fieldCnt;
  wire        softOut, pinReq, alignEv, hold, lineOut, frameOut, shutClr, gpClr;
  wire        coreN, osc, updLoad, wideEn, clampOut, outAct;
  int         fail_count = 0, total_checks = 0, hits;

  mtc_misc_regs i_mtc_misc_regs (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(rdData),
    .sharedPin(sharedPin), .frameSyncIn(frameSyncIn), .lineSyncIn(lineSyncIn),
    .lineCount(lineCount), .pixelBlank(pixelBlank), .clampPulse(clampPulse),
    .vertClkIn(vertClkIn), .fieldGateMask(fieldGateMask), .softResetOut_r(softOut),
    .pinResetReq_r(pinReq), .alignEvent_r(alignEv), .clockHold_r(hold),
    .lineSyncOut_r(lineOut), .frameSyncOut_r(frameOut), .vertClkOut_r(vOut),
    .sensorGateOut_r(gOut), .shutterClear_r(shutClr), .gpOutClear_r(gpClr),
    .fieldCount_r(fieldCnt), .coreResetN_r(coreN), .oscRun_r(osc),
    .updateLoad_r(updLoad), .wideCounterEn_r(wideEn), .clampOut_r(clampOut),
    .outputsActive_r(outAct));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Wait n edges, then settle
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One-cycle write
  task wr(input [7:0] a, input [27:0] d);
    @(posedge sys_clk);
    regWrEn <= 1; regAddr <= a; regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 0;
  endtask
  // One-cycle read, data checked in the following cycle
  task rd(input [7:0] a, input [27:0] e);
    @(posedge sys_clk);
    regRdEn <= 1; regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 0;
    #1;
    `CHK(rdData, e)
  endtask
  // Wait for the alignment pulse under a bound
  task wait_align;
    count_ev(20);
    `CHK(hits, 1)
  endtask
  // Count alignment pulses over n cycles
  task count_ev(input int n);
    hits = 0;
    repeat (n) begin cyc(1); if (alignEv === 1'b1) hits++; end
  endtask
  // Write alignment control, count cycles whose event and clears match pat
  task fire(input [27:0] d, input [2:0] pat);
    wr(8'h13, d);
    hits = 0;
    repeat (6) begin cyc(1); if ({alignEv, shutClr, gpClr} === pat) hits++; end
  endtask
  // Line edge, counting load pulses
  task line_edge(input [12:0] n);
    @(posedge sys_clk);
    lineCount <= n; lineSyncIn <= 1; hits = 0;
    repeat (4) begin cyc(1); if (updLoad === 1'b1) hits++; end
    `CHK(lineOut, 1'b1)
    @(posedge sys_clk);
    lineSyncIn <= 0;
    cyc(2);
  endtask

  // Defaults after reset, reserved place refuses writes
  task t_defaults;
    `CHK(wideEn, 1'b1)
    `CHK(coreN, 1'b0)
    `CHK(osc, 1'b0)
    `CHK(outAct, 1'b0)
    rd(8'h10, 28'h0);
    rd(8'h12, 28'h1);
    rd(8'h13, 28'h61);
    rd(8'h16, 28'h1);
    rd(8'h1B, 28'hA);
    rd(8'h1F, 28'h3);
    wr(8'h1E, 28'hFFFFFFF);
    rd(8'h1E, 28'h0);
    rd(8'h05, 28'h0);
  endtask
  // Core and oscillator run bits
  task t_run;
    wr(8'h14, 28'h1);
    wr(8'h15, 28'h1);
    wr(8'h1F, 28'h2);
    cyc(2);
    `CHK(wideEn, 1'b0)
    `CHK(coreN, 1'b1)
    `CHK(osc, 1'b1)
    rd(8'h15, 28'h1);
  endtask
  // Output gate waits for a frame edge
  task t_gate_open;
    wr(8'h11, 28'h1);
    cyc(6);
    `CHK(outAct, 1'b0)
    @(posedge sys_clk);
    frameSyncIn <= 1;
    cyc(3);
    `CHK(outAct, 1'b1)
    `CHK(frameOut, 1'b1)
    @(posedge sys_clk);
    frameSyncIn <= 0;
    rd(8'h11, 28'h1);
  endtask
  // Software trigger steps, then zeroes, the field counter
  task t_sw_align;
    wr(8'h13, 28'h0020061 | 28'h1000000); wait_align;
    `CHK(fieldCnt, 8'h01)
    wr(8'h13, 28'h0020061 | 28'h1000000); wait_align;
    `CHK(fieldCnt, 8'h02)
    rd(8'h13, 28'h0020061);
    wr(8'h13, 28'h1000061); wait_align;
    `CHK(fieldCnt, 8'h00)
  endtask
  // Pin as alignment input with clock hold, then as reset input
  task t_pin;
    @(posedge sys_clk);
    vertClkIn <= 24'hFFFFFF;
    wr(8'h12, 28'h0);
    wr(8'h13, 28'h0000065);
    @(posedge sys_clk);
    sharedPin <= 0; frameSyncIn <= 1; lineSyncIn <= 1;
    cyc(6);
    `CHK(hold, 1'b1)
    `CHK(vOut, 24'h0)
    `CHK(frameOut, 1'b0)
    `CHK(lineOut, 1'b1)
    @(posedge sys_clk);
    sharedPin <= 1;
    wait_align;
    `CHK(hold, 1'b0)
    `CHK(vOut, 24'hFFFFFF)
    `CHK(frameOut, 1'b1)
    wr(8'h12, 28'h1);
    frameSyncIn <= 0; lineSyncIn <= 0; sharedPin <= 0;
    count_ev(8);
    `CHK(pinReq, 1'b1)
    `CHK(hits, 0)
    @(posedge sys_clk);
    sharedPin <= 1;
    cyc(6);
    `CHK(pinReq, 1'b0)
  endtask
  // Enhanced clears follow a software alignment only when enabled
  task t_enhanced;
    fire(28'h1018069, 3'b111); `CHK(hits, 1)
    fire(28'h1018061, 3'b100); `CHK(hits, 1)
    fire(28'h1008069, 3'b110); `CHK(hits, 1)
    wr(8'h13, 28'h2000061);
    cyc(2);
    `CHK(shutClr, 1'b1)
    wr(8'h13, 28'h0000061);
    cyc(2);
    `CHK(shutClr, 1'b0)
  endtask
  // High-active pin, event on the leading edge only
  task t_edge_mode;
    wr(8'h13, 28'h0004003);
    sharedPin <= 0;
    cyc(4);
    wr(8'h12, 28'h0);
    @(posedge sys_clk);
    sharedPin <= 1;
    count_ev(8); `CHK(hits, 1)
    @(posedge sys_clk);
    sharedPin <= 0;
    count_ev(8); `CHK(hits, 0)
    wr(8'h12, 28'h1);
  endtask
  // Gate select and mask override
  task t_sensor_gate;
    wr(8'h1C, 28'h000003);
    cyc(2);
    `CHK(gOut, 24'h000003)
    `CHK(vOut, 24'hFFFFFC)
    @(posedge sys_clk);
    fieldGateMask <= 24'h000001;
    cyc(3);
    `CHK(gOut, 24'h000002)
    wr(8'h1D, 28'h1000002);
    cyc(2);
    `CHK(gOut, 24'h000001)
  endtask
  // Update line match and block
  task t_update;
    wr(8'h17, 28'h5);
    line_edge(13'h5); `CHK(hits, 1)
    line_edge(13'h4); `CHK(hits, 0)
    wr(8'h17, 28'h2005);
    line_edge(13'h5); `CHK(hits, 0)
  endtask
  // Clamp inhibited during blanking
  task t_clamp;
    @(posedge sys_clk);
    clampPulse <= 1; pixelBlank <= 1;
    cyc(3);
    `CHK(clampOut, 1'b0)
    @(posedge sys_clk);
    pixelBlank <= 0;
    cyc(3);
    `CHK(clampOut, 1'b1)
    @(posedge sys_clk);
    clampPulse <= 0;
  endtask
  // Soft reset restores defaults
  task t_soft;
    wr(8'h10, 28'h1);
    cyc(1);
    `CHK(softOut, 1'b1)
    cyc(2);
    `CHK(outAct, 1'b0)
    rd(8'h10, 28'h0);
    rd(8'h14, 28'h0);
    rd(8'h1C, 28'h0);
    rd(8'h13, 28'h61);
  endtask

  // Verdict
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1;
    cyc(1);
    t_defaults;
    t_run;
    t_gate_open;
    t_sw_align;
    t_pin;
    t_enhanced;
    t_edge_mode;
    t_sensor_gate;
    t_update;
    t_clamp;
    t_soft;
    report_and_stop;
  end
endmodule // mtc_misc_regs_tb
